// *** sstat_pkg.sv ***
// Package for the status register group: offsets, reset values, field positions, event carriers.
package sstat_pkg;

	localparam logic [7:0] SSTAT_OFF_DMA_EVENT = 8'h0C;
	localparam logic [7:0] SSTAT_OFF_SCSI_EVENT = 8'h0D;
	localparam logic [7:0] SSTAT_OFF_LATCH_ARB = 8'h0E;
	localparam logic [7:0] SSTAT_OFF_FIFO_PHASE = 8'h0F;
	localparam logic [7:0] SSTAT_OFF_ROLE_DIR = 8'h14;
	// Mask and control registers kept locally.
	localparam logic [7:0] SSTAT_OFF_SCSI_IEN = 8'h03;
	localparam logic [7:0] SSTAT_OFF_DMA_IEN = 8'h39;
	localparam logic [7:0] SSTAT_OFF_CTRL = 8'h40;

	localparam logic [7:0] SSTAT_RST_DMA_EVENT = 8'h80;
	localparam logic [7:0] SSTAT_RST_SCSI_EVENT = 8'h00;
	localparam logic [7:0] SSTAT_RST_IEN = 8'h00;
	localparam logic [7:0] SSTAT_RST_CTRL = 8'h00;

	// Field positions in the dma event register.
	localparam int SSTAT_DMA_FIFO_EMPTY_BIT = 7;
	localparam int SSTAT_DMA_ABORT_BIT = 4;
	localparam int SSTAT_DMA_STEP_BIT = 3;
	localparam int SSTAT_DMA_PROG_BIT = 2;
	localparam int SSTAT_DMA_WDOG_BIT = 1;
	localparam int SSTAT_DMA_ILLEGAL_BIT = 0;
	// Field positions in the local control register.
	localparam int SSTAT_CTL_SOFT_ABORT_BIT = 7;
	localparam int SSTAT_CTL_SINGLE_STEP_BIT = 4;
	localparam int SSTAT_CTL_PIPELINE_BIT = 3;
	localparam int SSTAT_CTL_PARITY_CHECK_BIT = 2;
	localparam int SSTAT_CTL_PASS_PARITY_BIT = 1;
	localparam int SSTAT_CTL_SEL_ENABLE_BIT = 0;

	localparam int SSTAT_SYNC_FIFO_DEPTH = 8;
	localparam int SSTAT_DMA_FIFO_BYTES = 36;

	localparam int SSTAT_SEL_TIMEOUT_MS = 250;
	localparam int SSTAT_CLK_HZ = 20000000;
	localparam int SSTAT_SEL_TIMEOUT_CYCLES = SSTAT_SEL_TIMEOUT_MS * (SSTAT_CLK_HZ / 1000);

	typedef struct packed {
		logic abort_in_n;
		logic parity_gen_mode;
		logic instr_done;
		logic branch_taken;
		logic int_instr;
		logic illegal_fetch;
		logic bus_master;
		logic wdog_zero;
		logic [5:0] dma_fifo_count;
	} sstat_dma_evt_t;

	typedef struct packed {
		logic target_role;
		logic phase_mismatch;
		logic atn_seen;
		logic arb_done;
		logic sel_start;
		logic sel_response;
		logic selected_by_other;
		logic gross_error;
		logic disconnect;
		logic expected_disconnect;
		logic low_level_mode;
		logic rst_line;
		logic assert_rst_ctl;
		logic scsi_parity_err;
		logic host_parity_err;
	} sstat_scsi_evt_t;

	typedef struct packed {
		logic input_latch_full;
		logic output_latch_full;
		logic output_buffer_full;
		logic arbitration_in_progress;
		logic arbitration_lost;
		logic arbitration_won;
		logic parity_line;
		logic [3:0] sync_fifo_count;
		logic latched_parity;
		logic [2:0] latched_phase;
		logic actual_target_role;
		logic transfer_direction;
	} sstat_live_t;

endpackage : sstat_pkg

// *** sstat_regs.sv ***
// Status register group: sticky event flags, masks, live bus status and register port.
//
// Functional notes
// R01: Reading dma status clears DMA causes.
// R02: Fifo empty flag reads one when empty.
// R03: Abort flag from pin or software.
// R04: Single step flag per instruction or branch.
// R05: Interrupt instruction and illegal opcode flags.
// R06: Watchdog flag when master and counter zero.
// R07: Software spaces consecutive status reads apart.
// R08: Every scsi event bit individually maskable.
// R09: Phase mismatch or attention sets bit seven.
// R10: Arbitration completion sets function complete.
// R11: Selection timeout after 250 milliseconds.
// R12: Selected flag only when selection enabled.
// R13: Any gross error condition sets flag.
// R14: Unexpected disconnect only as initiator.
// R15: Reset flag once per reset assertion.
// R16: Parity flag only with checking enabled.
// R17: Input latch full flag shown live.
// R18: Separate output latch and buffer flags.
// R19: Arbitration progress, lost and won bits.
// R20: Live reset and parity line bits.
// R21: Sync fifo byte count in upper nibble.
// R22: Latched parity and phase bits shown.
// R23: Interrupt output from unmasked pending flags.
// R24: Event during clearing read stays pending.
//
// The implementer's own choice: the plain strobed port.
module sstat_regs
	import sstat_pkg::*;
#(
	parameter int SEL_TIMEOUT_CYCLES = SSTAT_SEL_TIMEOUT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire sstat_dma_evt_t dma_evt,
	input wire sstat_scsi_evt_t scsi_evt,
	input wire sstat_live_t live,
	output logic irq_n
);

	logic [7:0] dma_flags_r;
	logic [7:0] scsi_flags_r;
	logic [7:0] dma_ien_r;
	logic [7:0] scsi_ien_r;
	logic [7:0] ctrl_r;
	logic [7:0] rdata_r;
	logic [1:0] abort_sync_r;
	logic [1:0] rst_sync_r;
	logic [1:0] par_sync_r;
	logic rst_prev_r;
	logic [31:0] sel_timer_r;
	logic sel_wait_r;
	logic [7:0] dma_set;
	logic [7:0] scsi_set;
	logic [7:0] live_dma;
	logic rst_level;
	logic rd_dma;
	logic rd_scsi;
	logic sel_timeout;

	assign rd_dma = reg_rd && (reg_addr == SSTAT_OFF_DMA_EVENT);
	assign rd_scsi = reg_rd && (reg_addr == SSTAT_OFF_SCSI_EVENT);

	// The abort pin and reset line come from outside, so synchronise them.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			abort_sync_r <= 2'h0;
			rst_sync_r <= 2'h0;
			par_sync_r <= 2'h0;
		end else begin
			abort_sync_r <= {abort_sync_r[0], ~dma_evt.abort_in_n};
			rst_sync_r <= {rst_sync_r[0], scsi_evt.rst_line};
			par_sync_r <= {par_sync_r[0], live.parity_line};
		end
	end

	assign rst_level = rst_sync_r[1] | scsi_evt.assert_rst_ctl;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_prev_r <= 1'b0;
		end else begin
			rst_prev_r <= rst_level;
		end
	end

	// R11: selection timer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_wait_r <= 1'b0;
			sel_timer_r <= 32'h0000_0000;
		end else if (scsi_evt.sel_start) begin
			sel_wait_r <= 1'b1;
			sel_timer_r <= 32'h0000_0000;
		end else if (sel_wait_r) begin
			if (scsi_evt.sel_response || sel_timeout) begin
				sel_wait_r <= 1'b0;
			end
			sel_timer_r <= sel_timer_r + 32'h0000_0001;
		end
	end

	assign sel_timeout = sel_wait_r && !scsi_evt.sel_response
		&& (sel_timer_r == 32'(SEL_TIMEOUT_CYCLES - 1));

	always_comb begin
		dma_set = 8'h00;
		// R03: abort sources
		dma_set[SSTAT_DMA_ABORT_BIT] = (abort_sync_r[1] && dma_evt.parity_gen_mode)
			|| (reg_wr && reg_addr == SSTAT_OFF_CTRL && reg_wdata[SSTAT_CTL_SOFT_ABORT_BIT]);
		// R04: single step sources
		dma_set[SSTAT_DMA_STEP_BIT] =
			(dma_evt.instr_done && ctrl_r[SSTAT_CTL_SINGLE_STEP_BIT])
			|| (dma_evt.branch_taken && ctrl_r[SSTAT_CTL_PIPELINE_BIT]);
		// R05: program and illegal events
		dma_set[SSTAT_DMA_PROG_BIT] = dma_evt.int_instr;
		dma_set[SSTAT_DMA_ILLEGAL_BIT] = dma_evt.illegal_fetch;
		// R06: watchdog in master mode
		dma_set[SSTAT_DMA_WDOG_BIT] = dma_evt.bus_master && dma_evt.wdog_zero;
	end

	always_comb begin
		scsi_set = 8'h00;
		// R09: mismatch or attention
		scsi_set[7] = scsi_evt.target_role ? scsi_evt.atn_seen : scsi_evt.phase_mismatch;
		// R10: arbitration finished
		scsi_set[6] = scsi_evt.arb_done;
		scsi_set[5] = sel_timeout;
		// R12: selection needs enable
		scsi_set[4] = scsi_evt.selected_by_other && ctrl_r[SSTAT_CTL_SEL_ENABLE_BIT];
		// R13: gross error summary
		scsi_set[3] = scsi_evt.gross_error;
		// R14: initiator disconnect
		scsi_set[2] = !scsi_evt.target_role && scsi_evt.disconnect
			&& (scsi_evt.low_level_mode || !scsi_evt.expected_disconnect);
		// R15: edge of reset
		scsi_set[1] = rst_level && !rst_prev_r;
		// R16: parity gated by check enable
		scsi_set[0] = ctrl_r[SSTAT_CTL_PARITY_CHECK_BIT] && (scsi_evt.scsi_parity_err
			|| (scsi_evt.host_parity_err && ctrl_r[SSTAT_CTL_PASS_PARITY_BIT]));
	end

	// R01: read clears, set wins
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dma_flags_r <= SSTAT_RST_DMA_EVENT;
		end else if (rd_dma) begin
			// R24: set beats clear
			dma_flags_r <= dma_set;
		end else begin
			dma_flags_r <= dma_flags_r | dma_set;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			scsi_flags_r <= SSTAT_RST_SCSI_EVENT;
		end else if (rd_scsi) begin
			// R24: set beats clear
			scsi_flags_r <= scsi_set;
		end else begin
			scsi_flags_r <= scsi_flags_r | scsi_set;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dma_ien_r <= SSTAT_RST_IEN;
			scsi_ien_r <= SSTAT_RST_IEN;
			ctrl_r <= SSTAT_RST_CTRL;
		end else if (reg_wr) begin
			if (reg_addr == SSTAT_OFF_DMA_IEN) begin
				dma_ien_r <= reg_wdata;
			end
			if (reg_addr == SSTAT_OFF_SCSI_IEN) begin
				scsi_ien_r <= reg_wdata;
			end
			// The soft abort bit is a command, so it is not stored.
			if (reg_addr == SSTAT_OFF_CTRL) begin
				ctrl_r <= {1'b0, reg_wdata[6:0]};
			end
		end
	end

	// R02: live empty flag
	always_comb begin
		live_dma = dma_flags_r;
		live_dma[SSTAT_DMA_FIFO_EMPTY_BIT] = (dma_evt.dma_fifo_count == 6'h00);
		live_dma[6:5] = 2'h0;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				SSTAT_OFF_DMA_EVENT: rdata_r <= live_dma;
				SSTAT_OFF_SCSI_EVENT: rdata_r <= scsi_flags_r;
				// R17: latch and arbitration status
				// R18: output latch and buffer
				// R19: arbitration bits
				// R20: live reset and parity
				SSTAT_OFF_LATCH_ARB: rdata_r <= {live.input_latch_full,
					live.output_buffer_full, live.output_latch_full,
					live.arbitration_in_progress, live.arbitration_lost,
					live.arbitration_won, rst_sync_r[1], par_sync_r[1]};
				// R21: fifo count
				// R22: latched parity and phase
				SSTAT_OFF_FIFO_PHASE: rdata_r <= {live.sync_fifo_count,
					live.latched_parity, live.latched_phase};
				SSTAT_OFF_ROLE_DIR: rdata_r <= {6'h00, live.actual_target_role,
					live.transfer_direction};
				SSTAT_OFF_DMA_IEN: rdata_r <= dma_ien_r;
				SSTAT_OFF_SCSI_IEN: rdata_r <= scsi_ien_r;
				SSTAT_OFF_CTRL: rdata_r <= ctrl_r;
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata = rdata_r;

	// R23: unmasked pending causes
	// R08: per-bit scsi masks
	assign irq_n = ~(|(dma_flags_r[4:0] & dma_ien_r[4:0]) | |(scsi_flags_r & scsi_ien_r));

	chk_read_clears_dma: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rd_dma && dma_set == 8'h00 |=> dma_flags_r[4:0] == 5'h00) // R01
		else $error("dma flags not cleared by read");

	chk_fifo_empty_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		live_dma[7] == (dma_evt.dma_fifo_count == 6'h00)) // R02
		else $error("fifo empty flag wrong");

	chk_step_needs_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!ctrl_r[4] && !ctrl_r[3] && !rd_dma && !dma_flags_r[3] |=> !dma_flags_r[3]) // R04
		else $error("single step flag without mode");

	chk_watchdog_master: assert property (@(posedge sys_clk) disable iff (!reset_n)
		dma_evt.bus_master && dma_evt.wdog_zero |=> dma_flags_r[1]) // R06
		else $error("watchdog flag missed");

	chk_sel_enable_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
		scsi_evt.selected_by_other && !ctrl_r[0] && !scsi_flags_r[4] |=> !scsi_flags_r[4]) // R12
		else $error("selected flag without enable");

	chk_reset_edge_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rst_level && rst_prev_r |-> !scsi_set[1]) // R15
		else $error("reset flag retriggered");

	chk_parity_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!ctrl_r[2] |-> !scsi_set[0]) // R16
		else $error("parity flag without checking");

	chk_set_beats_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rd_scsi && scsi_evt.arb_done |=> scsi_flags_r[6]) // R24
		else $error("event lost during read");

	chk_irq_follows: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(scsi_flags_r[5]) && scsi_ien_r[5] |-> !irq_n) // R23
		else $error("irq not asserted");

	// Each source must reach its flag one edge later, even when a read clears the register.
	// A set that lands on the clearing read is the case most likely to be lost.

	chk_read_clears_scsi: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rd_scsi && scsi_set == 8'h00 |=> scsi_flags_r == 8'h00) // R01
		else $error("scsi flags not cleared by read");

	chk_dma_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!rd_dma |=> &(dma_flags_r[4:0] | ~$past(dma_flags_r[4:0]))) // R24
		else $error("dma flag dropped without read");

	chk_scsi_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!rd_scsi |=> &(scsi_flags_r | ~$past(scsi_flags_r))) // R24
		else $error("scsi flag dropped without read");

	chk_abort_soft: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_wr && reg_addr == SSTAT_OFF_CTRL && reg_wdata[7] |=> dma_flags_r[4]) // R03
		else $error("software abort missed");

	chk_abort_pin: assert property (@(posedge sys_clk) disable iff (!reset_n)
		abort_sync_r[1] && dma_evt.parity_gen_mode |=> dma_flags_r[4]) // R03
		else $error("abort pin missed");

	chk_step_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		dma_evt.instr_done && ctrl_r[4] |=> dma_flags_r[3]) // R04
		else $error("single step flag missed");

	chk_prog_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		dma_evt.int_instr |=> dma_flags_r[2]) // R05
		else $error("program interrupt flag missed");

	chk_illegal_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		dma_evt.illegal_fetch |=> dma_flags_r[0]) // R05
		else $error("illegal instruction flag missed");

	chk_wdog_needs_master: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!dma_evt.bus_master && !rd_dma && !dma_flags_r[1] |=> !dma_flags_r[1]) // R06
		else $error("watchdog flag while not master");

	chk_mismatch_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!scsi_evt.target_role && scsi_evt.phase_mismatch |=> scsi_flags_r[7]) // R09
		else $error("phase mismatch flag missed");

	chk_atn_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		scsi_evt.target_role && scsi_evt.atn_seen |=> scsi_flags_r[7]) // R09
		else $error("attention flag missed");

	chk_complete_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		scsi_evt.arb_done |=> scsi_flags_r[6]) // R10
		else $error("function complete flag missed");

	chk_timeout_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sel_timeout |=> scsi_flags_r[5]) // R11
		else $error("selection timeout flag missed");

	chk_response_stops: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sel_wait_r && scsi_evt.sel_response && !scsi_evt.sel_start |=> !sel_wait_r) // R11
		else $error("selection timer kept running");

	chk_selected_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		scsi_evt.selected_by_other && ctrl_r[0] |=> scsi_flags_r[4]) // R12
		else $error("selected flag missed");

	chk_gross_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
		scsi_evt.gross_error |=> scsi_flags_r[3]) // R13
		else $error("gross error flag missed");

	chk_disc_target: assert property (@(posedge sys_clk) disable iff (!reset_n)
		scsi_evt.target_role && !rd_scsi && !scsi_flags_r[2] |=> !scsi_flags_r[2]) // R14
		else $error("disconnect flag as target");

	chk_reset_flag_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rst_level && !rst_prev_r |=> scsi_flags_r[1]) // R15
		else $error("reset flag missed");

	chk_parity_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ctrl_r[2] && scsi_evt.scsi_parity_err |=> scsi_flags_r[0]) // R16
		else $error("parity flag missed");

	chk_irq_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		scsi_flags_r == 8'h00 && dma_flags_r[4:0] == 5'h00 |-> irq_n) // R23
		else $error("irq without pending cause");

	// Read data must show the live inputs as they stood on the strobe edge.

	chk_dma_reserved: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_rd && reg_addr == SSTAT_OFF_DMA_EVENT |=> reg_rdata[6:5] == 2'h0) // R02
		else $error("dma reserved bits not zero");

	chk_latch_shown: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_rd && reg_addr == SSTAT_OFF_LATCH_ARB
		|=> reg_rdata[7] == $past(live.input_latch_full)) // R17
		else $error("input latch flag wrong");

	chk_buffer_shown: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_rd && reg_addr == SSTAT_OFF_LATCH_ARB
		|=> reg_rdata[6] == $past(live.output_buffer_full)) // R18
		else $error("output buffer flag wrong");

	chk_reset_live: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_rd && reg_addr == SSTAT_OFF_LATCH_ARB |=> reg_rdata[1] == $past(rst_sync_r[1])) // R20
		else $error("reset line bit wrong");

	chk_count_shown: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_rd && reg_addr == SSTAT_OFF_FIFO_PHASE
		|=> reg_rdata[7:4] == $past(live.sync_fifo_count)) // R21
		else $error("fifo count wrong");

	chk_phase_shown: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_rd && reg_addr == SSTAT_OFF_FIFO_PHASE
		|=> reg_rdata[2:0] == $past(live.latched_phase)) // R22
		else $error("latched phase wrong");

endmodule : sstat_regs

// *** tb_sstat_regs.sv ***
// Self-checking bench for the status register group.
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); \
	end \
end

module tb_sstat_regs
	import sstat_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] DMA = SSTAT_OFF_DMA_EVENT;
	localparam logic [7:0] SCS = SSTAT_OFF_SCSI_EVENT;
	localparam logic [7:0] CTL = SSTAT_OFF_CTRL;
	logic sys_clk = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [7:0] reg_rdata;
	logic irq_n;
	sstat_dma_evt_t dma_evt = '{abort_in_n: 1'h1, default: '0};
	sstat_scsi_evt_t scsi_evt = '0;
	sstat_live_t live = '0;
	int n_mismatch = 0;
	int n_compared = 0;

	always #25 sys_clk = ~sys_clk;

	// A short selection timeout keeps the run brief.
	sstat_regs #(.SEL_TIMEOUT_CYCLES(20)) DUT (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.dma_evt(dma_evt),
		.scsi_evt(scsi_evt),
		.live(live),
		.irq_n(irq_n)
	);

	task automatic conclude();
		$display("Compared %0d values, %0d mismatches", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rchk

	task automatic pd(input sstat_dma_evt_t m);
		@(posedge sys_clk);
		dma_evt <= dma_evt | m;
		@(posedge sys_clk);
		dma_evt <= dma_evt & ~m;
	endtask : pd

	task automatic ps(input sstat_scsi_evt_t m);
		@(posedge sys_clk);
		scsi_evt <= scsi_evt | m;
		@(posedge sys_clk);
		scsi_evt <= scsi_evt & ~m;
	endtask : ps

	// Each event is read once to see it, then again to see it cleared.
	task automatic dv(input sstat_dma_evt_t m, input logic [7:0] e);
		pd(m);
		idle(3);
		rchk(DMA, e);
		rchk(DMA, 8'h80);
	endtask : dv

	task automatic ev(input sstat_scsi_evt_t m, input logic [7:0] e);
		ps(m);
		idle(4);
		rchk(SCS, e);
		rchk(SCS, 8'h00);
	endtask : ev

	// The pin passes a synchroniser, so it is held for two cycles.
	task automatic abortpin(input logic mode, input logic [7:0] e);
		@(posedge sys_clk);
		dma_evt.abort_in_n <= 1'h0;
		dma_evt.parity_gen_mode <= mode;
		idle(2);
		dma_evt.abort_in_n <= 1'h1;
		idle(4);
		rchk(DMA, e);
		rchk(DMA, 8'h80);
	endtask : abortpin

	// The event arrives on the very edge that takes the clearing read.
	task automatic race(input logic [7:0] a, input sstat_dma_evt_t dm, input sstat_scsi_evt_t sm,
			input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		dma_evt <= dma_evt | dm;
		scsi_evt <= scsi_evt | sm;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		dma_evt <= dma_evt & ~dm;
		scsi_evt <= scsi_evt & ~sm;
		idle(2);
		rchk(a, e);
	endtask : race

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		conclude();
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'h1;
		rchk(DMA, SSTAT_RST_DMA_EVENT);
		rchk(SCS, SSTAT_RST_SCSI_EVENT);
		rchk(SSTAT_OFF_LATCH_ARB, 8'h00);
		rchk(SSTAT_OFF_FIFO_PHASE, 8'h00);
		rchk(8'h20, 8'h00);
		wr(8'h21, 8'hFF);
		wr(SSTAT_OFF_SCSI_IEN, 8'hA5);
		rchk(SSTAT_OFF_SCSI_IEN, 8'hA5);
		wr(CTL, 8'h80);
		rchk(CTL, 8'h00);
		rchk(DMA, 8'h90);
		rchk(DMA, 8'h80);
		abortpin(1'h1, 8'h90);
		abortpin(1'h0, 8'h80);
		dv('{int_instr: 1'h1, default: '0}, 8'h84);
		dv('{illegal_fetch: 1'h1, default: '0}, 8'h81);
		dv('{instr_done: 1'h1, default: '0}, 8'h80);
		wr(CTL, 8'h10);
		dv('{instr_done: 1'h1, default: '0}, 8'h88);
		wr(CTL, 8'h08);
		dv('{branch_taken: 1'h1, default: '0}, 8'h88);
		dv('{wdog_zero: 1'h1, default: '0}, 8'h80);
		dv('{wdog_zero: 1'h1, bus_master: 1'h1, default: '0}, 8'h82);
		dma_evt.dma_fifo_count <= 6'h24;
		idle(2);
		rchk(DMA, 8'h00);
		dma_evt.dma_fifo_count <= 6'h00;
		wr(SSTAT_OFF_DMA_IEN, 8'h1F);
		pd('{int_instr: 1'h1, default: '0});
		idle(2);
		`CHK(irq_n, 1'h0)
		rchk(DMA, 8'h84);
		`CHK(irq_n, 1'h1)
		wr(SSTAT_OFF_DMA_IEN, 8'h1B);
		pd('{int_instr: 1'h1, default: '0});
		idle(2);
		`CHK(irq_n, 1'h1)
		rchk(DMA, 8'h84);
		wr(CTL, 8'h00);
		wr(SSTAT_OFF_SCSI_IEN, 8'h00);
		ev('{phase_mismatch: 1'h1, default: '0}, 8'h80);
		ev('{atn_seen: 1'h1, target_role: 1'h1, default: '0}, 8'h80);
		ev('{phase_mismatch: 1'h1, target_role: 1'h1, default: '0}, 8'h00);
		ev('{arb_done: 1'h1, default: '0}, 8'h40);
		ev('{gross_error: 1'h1, default: '0}, 8'h08);
		ev('{disconnect: 1'h1, default: '0}, 8'h04);
		ev('{disconnect: 1'h1, expected_disconnect: 1'h1, default: '0}, 8'h00);
		ev('{disconnect: 1'h1, expected_disconnect: 1'h1, low_level_mode: 1'h1,
			default: '0}, 8'h04);
		ev('{disconnect: 1'h1, target_role: 1'h1, default: '0}, 8'h00);
		ev('{selected_by_other: 1'h1, default: '0}, 8'h00);
		ev('{scsi_parity_err: 1'h1, default: '0}, 8'h00);
		wr(CTL, 8'h05);
		ev('{selected_by_other: 1'h1, default: '0}, 8'h10);
		ev('{scsi_parity_err: 1'h1, default: '0}, 8'h01);
		ev('{host_parity_err: 1'h1, default: '0}, 8'h00);
		wr(CTL, 8'h07);
		ev('{host_parity_err: 1'h1, default: '0}, 8'h01);
		ev('{assert_rst_ctl: 1'h1, default: '0}, 8'h02);
		wr(SSTAT_OFF_SCSI_IEN, 8'h40);
		ps('{gross_error: 1'h1, default: '0});
		idle(2);
		`CHK(irq_n, 1'h1)
		ps('{arb_done: 1'h1, default: '0});
		idle(2);
		`CHK(irq_n, 1'h0)
		rchk(SCS, 8'h48);
		`CHK(irq_n, 1'h1)
		ps('{sel_start: 1'h1, default: '0});
		idle(10);
		rchk(SCS, 8'h00);
		idle(20);
		rchk(SCS, 8'h20);
		ps('{sel_start: 1'h1, default: '0});
		idle(5);
		ps('{sel_response: 1'h1, default: '0});
		idle(30);
		rchk(SCS, 8'h00);
		scsi_evt.rst_line <= 1'h1;
		idle(5);
		rchk(SCS, 8'h02);
		idle(5);
		rchk(SCS, 8'h00);
		rchk(SSTAT_OFF_LATCH_ARB, 8'h02);
		scsi_evt.rst_line <= 1'h0;
		idle(4);
		race(DMA, '{int_instr: 1'h1, default: '0}, '0, 8'h84);
		race(SCS, '0, '{arb_done: 1'h1, default: '0}, 8'h40);
		live <= '{input_latch_full: 1'h1, arbitration_won: 1'h1, parity_line: 1'h1,
			sync_fifo_count: 4'h8, latched_parity: 1'h1, latched_phase: 3'h5,
			actual_target_role: 1'h1, default: '0};
		idle(4);
		rchk(SSTAT_OFF_LATCH_ARB, 8'h85);
		rchk(SSTAT_OFF_FIFO_PHASE, 8'h8D);
		rchk(SSTAT_OFF_ROLE_DIR, 8'h02);
		live <= '{output_buffer_full: 1'h1, output_latch_full: 1'h1, latched_phase: 3'h2,
			arbitration_in_progress: 1'h1, arbitration_lost: 1'h1,
			transfer_direction: 1'h1, default: '0};
		idle(4);
		rchk(SSTAT_OFF_LATCH_ARB, 8'h78);
		rchk(SSTAT_OFF_FIFO_PHASE, 8'h02);
		rchk(SSTAT_OFF_ROLE_DIR, 8'h01);
		conclude();
	end

endmodule : tb_sstat_regs
